// File: verilog/pwmoc_pkg.sv
//----------------------------------------------------------------------
// PWM output pin control package
//----------------------------------------------------------------------
package pwmoc_pkg;

   //-------------------------------------------------------------------
   // Register map (byte addresses)
   //-------------------------------------------------------------------
   localparam logic [7:0] PWMOC_IOCTL_ADDR = 8'h00;
   localparam logic [7:0] PWMOC_PHASE_ADDR = 8'h04;
   localparam logic [7:0] PWMOC_SPHASE_ADDR = 8'h08;
   localparam logic [7:0] PWMOC_CTRL_ADDR = 8'h0c;
   localparam logic [7:0] PWMOC_UNLOCK_ADDR = 8'h10;
   localparam logic [7:0] PWMOC_STATUS_ADDR = 8'h14;

   //-------------------------------------------------------------------
   // Field positions and reset values
   //-------------------------------------------------------------------
   localparam int PWMOC_HOWN_BIT = 15;
   localparam int PWMOC_LOWN_BIT = 14;
   localparam int PWMOC_HINV_BIT = 13;
   localparam int PWMOC_LINV_BIT = 12;
   localparam int PWMOC_ARR_LSB = 10;
   localparam int PWMOC_HFEN_BIT = 9;
   localparam int PWMOC_LFEN_BIT = 8;
   localparam int PWMOC_FORCE_LSB = 6;
   localparam int PWMOC_TRIP_LSB = 4;
   localparam int PWMOC_LIMIT_LSB = 2;
   localparam logic [15:0] PWMOC_IOCTL_RESET = 16'hc000;
   localparam logic [15:0] PWMOC_PHASE_RESET = 16'h0000;
   // Control register: bit0 module_run, bit1 separate_timebase_select
   localparam int PWMOC_RUN_BIT = 0;
   localparam int PWMOC_ITB_BIT = 1;
   localparam logic [31:0] PWMOC_UNLOCK_KEY = 32'h0000_a55a;

   //-------------------------------------------------------------------
   // Types
   //-------------------------------------------------------------------
   typedef enum logic [1:0] {
      PWMOC_COMPL = 2'b00,
      PWMOC_REDUND = 2'b01,
      PWMOC_PUSHPULL = 2'b10,
      PWMOC_INDEP = 2'b11
   } pwmoc_arr_t;

   typedef struct packed {
      logic high_pin_owner;
      logic low_pin_owner;
      logic high_pin_invert;
      logic low_pin_invert;
      logic [1:0] pin_pair_arrangement;
      logic high_force_enable;
      logic low_force_enable;
      logic [1:0] force_levels;
      logic [1:0] trip_levels;
      logic [1:0] limit_levels;
      logic [1:0] spare;
   } pwmoc_ioctl_t;

   typedef struct packed {
      logic high;
      logic low;
   } pwmoc_pair_t;

endpackage : pwmoc_pkg

// File: verilog/pwmoc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for external levels
module pwmoc_sync (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Data
   input wire logic [1:0] d,
   output logic [1:0] q
);
   logic [1:0] meta_reg;

   // First stage read only by the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= 2'h0;
         q <= 2'h0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : pwmoc_sync

// File: verilog/pwmoc_gen.sv
`timescale 1ns/1ps
// Counter-based waveform source: phase offset or separate period
module pwmoc_gen (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Settings
   input wire logic run,
   input wire logic sep_tb,
   input wire logic [15:0] period,
   input wire logic [15:0] duty,
   input wire logic [15:0] offset,
   // Waveform
   output logic wave,
   output logic wrap
);
   logic [15:0] cnt_reg;
   logic [15:0] top;
   logic [15:0] shifted;

   // Separate timebase uses offset value as its own period
   assign top = sep_tb ? offset : period;
   assign wrap = run && (cnt_reg >= top);
   // Phase shift wraps modulo 16 bits on purpose
   assign shifted = sep_tb ? cnt_reg : 16'(cnt_reg + offset);

   // Free-running counter while module runs
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || wrap) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // Duty compare against phase-shifted count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave <= 1'b0;
      end else begin
         wave <= run && (shifted < duty);
      end
   end
endmodule : pwmoc_gen

// File: verilog/pwmoc_top.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// PWM output stage with AXI4-Lite register access
module pwmoc_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Device configuration and conditions
   input wire logic write_protect_config,
   input wire logic trip_in,
   input wire logic limit_in,
   // Generator settings from the time base
   input wire logic [15:0] period,
   input wire logic [15:0] duty,
   // GPIO levels for unowned pins
   input wire logic gpio_high,
   input wire logic gpio_low,
   // Pins
   output logic high_side_output,
   output logic low_side_output
);
   //-------------------------------------------------------------------
   // Registers
   //-------------------------------------------------------------------
   pwmoc_pkg::pwmoc_ioctl_t ioctl_reg;
   logic [15:0] phase_reg;
   logic [15:0] sphase_reg;
   logic module_run_reg;
   logic separate_timebase_select_reg;
   logic unlocked_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic pp_phase_reg;
   logic [1:0] cond_sync;
   logic trip_act;
   logic limit_act;
   logic wr_fire;
   logic ioctl_ok;
   logic wave_h;
   logic wave_l;
   logic wrap_h;
   logic wrap_l;
   logic indep;
   pwmoc_pkg::pwmoc_pair_t gen_pair;
   pwmoc_pkg::pwmoc_pair_t pin_next;

   // Merge 16-bit register with byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   //-------------------------------------------------------------------
   // Condition inputs from pins
   //-------------------------------------------------------------------
   pwmoc_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({trip_in, limit_in}),
      .q(cond_sync)
   );
   assign trip_act = cond_sync[1];
   assign limit_act = cond_sync[0];

   //-------------------------------------------------------------------
   // AXI4-Lite write side
   //-------------------------------------------------------------------
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

   // Capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready;
         s_axi_wready <= !w_held_reg && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Response: OKAY for mapped, SLVERR otherwise or when locked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         case (awaddr_reg)
            pwmoc_pkg::PWMOC_IOCTL_ADDR:
               s_axi_bresp <= ioctl_ok ? 2'b00 : 2'b10;
            pwmoc_pkg::PWMOC_PHASE_ADDR,
            pwmoc_pkg::PWMOC_SPHASE_ADDR,
            pwmoc_pkg::PWMOC_CTRL_ADDR,
            pwmoc_pkg::PWMOC_UNLOCK_ADDR,
            pwmoc_pkg::PWMOC_STATUS_ADDR: s_axi_bresp <= 2'b00;
            default: s_axi_bresp <= 2'b10;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign ioctl_ok = !write_protect_config || unlocked_reg;

   // Unlock arms one control write, consumed by it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unlocked_reg <= 1'b0;
      end else if (wr_fire) begin
         if (awaddr_reg == pwmoc_pkg::PWMOC_UNLOCK_ADDR) begin
            unlocked_reg <= (wdata_reg == pwmoc_pkg::PWMOC_UNLOCK_KEY);
         end else if (awaddr_reg == pwmoc_pkg::PWMOC_IOCTL_ADDR) begin
            unlocked_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ioctl_reg <= pwmoc_pkg::PWMOC_IOCTL_RESET;
      end else if (wr_fire && ioctl_ok &&
                   awaddr_reg == pwmoc_pkg::PWMOC_IOCTL_ADDR) begin
         // Arrangement change while running is software's hazard
         ioctl_reg <= merge16(ioctl_reg, wdata_reg, wstrb_reg);
      end
   end

   // Offset and run registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg <= pwmoc_pkg::PWMOC_PHASE_RESET;
         sphase_reg <= pwmoc_pkg::PWMOC_PHASE_RESET;
         module_run_reg <= 1'b0;
         separate_timebase_select_reg <= 1'b0;
      end else if (wr_fire) begin
         case (awaddr_reg)
            pwmoc_pkg::PWMOC_PHASE_ADDR:
               phase_reg <= merge16(phase_reg, wdata_reg, wstrb_reg);
            pwmoc_pkg::PWMOC_SPHASE_ADDR:
               sphase_reg <= merge16(sphase_reg, wdata_reg, wstrb_reg);
            pwmoc_pkg::PWMOC_CTRL_ADDR: begin
               if (wstrb_reg[0]) begin
                  module_run_reg <= wdata_reg[pwmoc_pkg::PWMOC_RUN_BIT];
                  separate_timebase_select_reg <=
                     wdata_reg[pwmoc_pkg::PWMOC_ITB_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   //-------------------------------------------------------------------
   // AXI4-Lite read side
   //-------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               pwmoc_pkg::PWMOC_IOCTL_ADDR: s_axi_rdata <= {16'h0000, ioctl_reg};
               pwmoc_pkg::PWMOC_PHASE_ADDR: s_axi_rdata <= {16'h0000, phase_reg};
               pwmoc_pkg::PWMOC_SPHASE_ADDR:
                  s_axi_rdata <= {16'h0000, sphase_reg};
               pwmoc_pkg::PWMOC_CTRL_ADDR:
                  s_axi_rdata <= {30'h0, separate_timebase_select_reg,
                                  module_run_reg};
               pwmoc_pkg::PWMOC_UNLOCK_ADDR: s_axi_rdata <= 32'h0000_0000;
               pwmoc_pkg::PWMOC_STATUS_ADDR:
                  s_axi_rdata <= {25'h0, unlocked_reg, trip_act, limit_act,
                                  pp_phase_reg, high_side_output,
                                  low_side_output, write_protect_config};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   //-------------------------------------------------------------------
   // Waveform sources
   //-------------------------------------------------------------------
   assign indep = ioctl_reg.pin_pair_arrangement == pwmoc_pkg::PWMOC_INDEP;

   // Primary offset: phase or separate period
   pwmoc_gen u_gen_h (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(module_run_reg),
      .sep_tb(separate_timebase_select_reg),
      .period(period),
      .duty(duty),
      .offset(phase_reg),
      .wave(wave_h),
      .wrap(wrap_h)
   );

   // Secondary offset only in independent mode
   pwmoc_gen u_gen_l (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(module_run_reg),
      .sep_tb(separate_timebase_select_reg),
      .period(period),
      .duty(duty),
      .offset(indep ? sphase_reg : phase_reg),
      .wave(wave_l),
      .wrap(wrap_l)
   );

   // Push-pull period toggle
   always_ff @(posedge aclk) begin
      if (!aresetn || !module_run_reg) begin
         pp_phase_reg <= 1'b0;
      end else if (wrap_h) begin
         pp_phase_reg <= !pp_phase_reg;
      end
   end

   //-------------------------------------------------------------------
   // Pin resolution
   //-------------------------------------------------------------------
   always_comb begin
      case (ioctl_reg.pin_pair_arrangement)
         pwmoc_pkg::PWMOC_COMPL: gen_pair = '{high: wave_h, low: !wave_h};
         pwmoc_pkg::PWMOC_REDUND: gen_pair = '{high: wave_h, low: wave_h};
         pwmoc_pkg::PWMOC_PUSHPULL:
            gen_pair = '{high: wave_h && !pp_phase_reg,
                         low: wave_h && pp_phase_reg};
         default: gen_pair = '{high: wave_h, low: wave_l};
      endcase
      pin_next.high = gen_pair.high ^ ioctl_reg.high_pin_invert;
      pin_next.low = gen_pair.low ^ ioctl_reg.low_pin_invert;
      if (limit_act) begin
         pin_next = ioctl_reg.limit_levels;
      end
      if (trip_act) begin
         pin_next = ioctl_reg.trip_levels;
      end
      if (ioctl_reg.high_force_enable) begin
         pin_next.high = ioctl_reg.force_levels[1];
      end
      if (ioctl_reg.low_force_enable) begin
         pin_next.low = ioctl_reg.force_levels[0];
      end
      // GPIO owns pins when owner bit clear
      if (!ioctl_reg.high_pin_owner) begin
         pin_next.high = gpio_high;
      end
      if (!ioctl_reg.low_pin_owner) begin
         pin_next.low = gpio_low;
      end
   end

   // Registered pin drivers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_side_output <= 1'b0;
         low_side_output <= 1'b0;
      end else begin
         high_side_output <= pin_next.high;
         low_side_output <= pin_next.low;
      end
   end

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   gpio_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ioctl_reg.high_pin_owner |=> high_side_output == $past(gpio_high))
      else $error("high pin not from gpio");
   gpio_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ioctl_reg.low_pin_owner |=> low_side_output == $past(gpio_low))
      else $error("low pin not from gpio");
   force_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ioctl_reg.high_pin_owner && ioctl_reg.high_force_enable
      |=> high_side_output == $past(ioctl_reg.force_levels[1]))
      else $error("high force level lost");
   force_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ioctl_reg.low_pin_owner && ioctl_reg.low_force_enable
      |=> low_side_output == $past(ioctl_reg.force_levels[0]))
      else $error("low force level lost");
   trip_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      trip_act && ioctl_reg.high_pin_owner && !ioctl_reg.high_force_enable
      |=> high_side_output == $past(ioctl_reg.trip_levels[1]))
      else $error("trip level lost");
   limit_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      limit_act && !trip_act && ioctl_reg.low_pin_owner &&
      !ioctl_reg.low_force_enable
      |=> low_side_output == $past(ioctl_reg.limit_levels[0]))
      else $error("limit level lost");
   lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && !ioctl_ok |=> $stable(ioctl_reg))
      else $error("locked write took effect");
   compl_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ioctl_reg == pwmoc_pkg::PWMOC_IOCTL_RESET && !limit_act && !trip_act
      |=> low_side_output == !high_side_output)
      else $error("complementary pair broken");
   pp_apart_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ioctl_reg[15:8] == 8'hc8 && !limit_act && !trip_act
      |=> !(high_side_output && low_side_output))
      else $error("push-pull pins on together");
endmodule : pwmoc_top

// File: tb/pwmoc_stage.sv
`timescale 1ns/1ps
// Power stage stand-in: reports fault and current limit to the block
module pwmoc_stage (
   // Clock
   input wire logic aclk,
   // Pin drive from the block
   input wire logic high_side_output,
   input wire logic low_side_output,
   // Conditions the bench asks the stage to raise
   input wire logic trip_req,
   input wire logic limit_req,
   // Condition reports back to the block
   output logic trip_in,
   output logic limit_in,
   output logic shoot_through
);
   // Quiet reports until the first edge
   initial begin
      trip_in = 1'b0;
      limit_in = 1'b0;
   end

   // Reports change just after an edge, like an external comparator
   always @(posedge aclk) begin
      trip_in <= trip_req;
      limit_in <= limit_req;
   end

   // Both switches on shorts the rail; legal only in redundant use
   assign shoot_through = high_side_output & low_side_output;
endmodule : pwmoc_stage

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam logic [1:0] OKAY = 2'b00;
   localparam logic [1:0] SLVERR = 2'b10;
   localparam logic [31:0] M16 = 32'h0000_ffff;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic wp = 1'b0, trip_req = 1'b0, limit_req = 1'b0, trip_in, limit_in;
   logic gpio_high = 1'b0, gpio_low = 1'b0;
   logic [15:0] period = 16'h0010, duty = 16'h0000;
   logic high_side_output, low_side_output;
   logic [65:0] exp_r[$];
   logic [1:0] exp_b[$];
   logic [65:0] note;
   logic [15:0] io;
   logic [1:0] pe;
   int n_errors = 0, comparisons = 0, k;

   pwmoc_top u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .write_protect_config(wp),
      .trip_in(trip_in), .limit_in(limit_in), .period(period),
      .duty(duty), .gpio_high(gpio_high), .gpio_low(gpio_low),
      .high_side_output(high_side_output),
      .low_side_output(low_side_output));

   pwmoc_stage u_stage (.aclk(aclk), .high_side_output(high_side_output),
      .low_side_output(low_side_output), .trip_req(trip_req),
      .limit_req(limit_req), .trip_in(trip_in), .limit_in(limit_in),
      .shoot_through());

   // 250 MHz clock
   initial forever #2 aclk = ~aclk;

   //-------------------------------------------------------------------
   // Checking and closing
   //-------------------------------------------------------------------
   task automatic check(input logic [33:0] s, input logic [33:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check

   task automatic complete_run();
      $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic stall();
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      complete_run();
   endtask : stall

   // Oldest note against each response, as it appears
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
         note = exp_r.pop_front();
         check({s_axi_rresp, s_axi_rdata & note[31:0]}, note[65:32]);
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready)
         check({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
   end

   //-------------------------------------------------------------------
   // Bus master; the extra edge up front avoids double assignment
   //-------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int i;
      exp_b.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 100) stall();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m, input logic [1:0] r);
      int i;
      exp_r.push_back({r, e & m, m});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      if (i == 100) stall();
   endtask : rd

   // Expected pins: ownership over force over trip over limit
   function automatic logic [1:0] pins(input pwmoc_pkg::pwmoc_ioctl_t c,
                                       input logic w);
      logic h, l;
      h = w ^ c.high_pin_invert;
      l = w ^ c.low_pin_invert ^
          (c.pin_pair_arrangement == pwmoc_pkg::PWMOC_COMPL);
      if (limit_req) {h, l} = c.limit_levels;
      if (trip_req) {h, l} = c.trip_levels;
      if (c.high_force_enable) h = c.force_levels[1];
      if (c.low_force_enable) l = c.force_levels[0];
      if (!c.high_pin_owner) h = gpio_high;
      if (!c.low_pin_owner) l = gpio_low;
      return {h, l};
   endfunction : pins

   //-------------------------------------------------------------------
   // Main sequence
   //-------------------------------------------------------------------
   initial begin
      void'($urandom(32'h3fe66c0d));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(pwmoc_pkg::PWMOC_IOCTL_ADDR, 32'hc000, M16, OKAY);
      rd(pwmoc_pkg::PWMOC_PHASE_ADDR, 32'h0, M16, OKAY);
      rd(pwmoc_pkg::PWMOC_SPHASE_ADDR, 32'h0, M16, OKAY);
      rd(pwmoc_pkg::PWMOC_STATUS_ADDR, 32'h2, 32'h37, OKAY);
      rd(8'h18, 32'h0, 32'hffff_ffff, SLVERR);
      wr(8'h18, 32'h1, SLVERR);
      $display("test reset done");
      // Offsets kept small so constant waves stay constant
      io = 16'($urandom) & 16'h00ff;
      wr(pwmoc_pkg::PWMOC_PHASE_ADDR, {16'h0, io}, OKAY);
      rd(pwmoc_pkg::PWMOC_PHASE_ADDR, {16'h0, io}, M16, OKAY);
      io = 16'($urandom) & 16'h00ff;
      wr(pwmoc_pkg::PWMOC_SPHASE_ADDR, {16'h0, io}, OKAY);
      rd(pwmoc_pkg::PWMOC_SPHASE_ADDR, {16'h0, io}, M16, OKAY);
      wr(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h3, OKAY);
      rd(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h3, 32'h3, OKAY);
      wr(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h0, OKAY);
      // every arrangement code, set while stopped
      for (k = 0; k < 4; k++) begin
         io = 16'hc000 | 16'(k << pwmoc_pkg::PWMOC_ARR_LSB);
         wr(pwmoc_pkg::PWMOC_IOCTL_ADDR, {16'h0, io}, OKAY);
         rd(pwmoc_pkg::PWMOC_IOCTL_ADDR, {16'h0, io}, M16, OKAY);
      end
      // Push-pull run, watched by the pin pair assertion
      wr(pwmoc_pkg::PWMOC_IOCTL_ADDR, 32'hc800, OKAY);
      duty <= 16'hffff;
      wr(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h1, OKAY);
      repeat (60) @(posedge aclk);
      wr(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h0, OKAY);
      duty <= 16'h0000;
      $display("test registers done");
      // random pin settings; push-pull phase is not predictable here
      for (k = 0; k < 40; k++) begin
         io = 16'($urandom);
         if (io[11:10] == 2'b10) io[11:10] = 2'b00;
         duty <= {16{io[0]}};
         {gpio_high, gpio_low, trip_req, limit_req} <= 4'($urandom);
         wr(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h0, OKAY);
         wr(pwmoc_pkg::PWMOC_IOCTL_ADDR, {16'h0, io}, OKAY);
         wr(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h1, OKAY);
         repeat (4) @(posedge aclk);
         pe = pins(io, io[0]);
         rd(pwmoc_pkg::PWMOC_STATUS_ADDR, {26'h0, trip_req, limit_req,
            1'b0, pe, 1'b0}, 32'h37, OKAY);
      end
      $display("test pins done");
      // locked control register needs the unlock key per write
      wr(pwmoc_pkg::PWMOC_CTRL_ADDR, 32'h0, OKAY);
      wp <= 1'b1;
      wr(pwmoc_pkg::PWMOC_IOCTL_ADDR, 32'hc000, SLVERR);
      rd(pwmoc_pkg::PWMOC_IOCTL_ADDR, {16'h0, io}, M16, OKAY);
      wr(pwmoc_pkg::PWMOC_UNLOCK_ADDR, pwmoc_pkg::PWMOC_UNLOCK_KEY, OKAY);
      wr(pwmoc_pkg::PWMOC_IOCTL_ADDR, 32'hc3c0, OKAY);
      rd(pwmoc_pkg::PWMOC_IOCTL_ADDR, 32'hc3c0, M16, OKAY);
      wr(pwmoc_pkg::PWMOC_IOCTL_ADDR, 32'hc000, SLVERR);
      wr(pwmoc_pkg::PWMOC_UNLOCK_ADDR, pwmoc_pkg::PWMOC_UNLOCK_KEY, OKAY);
      wr(pwmoc_pkg::PWMOC_UNLOCK_ADDR, 32'h0, OKAY);
      wr(pwmoc_pkg::PWMOC_IOCTL_ADDR, 32'hc000, SLVERR);
      // Both forced high over any trip or limit still raised
      rd(pwmoc_pkg::PWMOC_STATUS_ADDR, 32'h7, 32'h7, OKAY);
      $display("test lock done");
      complete_run();
   end
endmodule : tb_top
